// >>> pkg/sleep_ctrl_defs.svh
// Purpose: Constants for the sleep controller and its output timers.
// Assumes: 20 MHz system clock.
// Notes:   Command selectors and unset defaults are local choices.
`ifndef SLEEP_CTRL_DEFS_SVH
`define SLEEP_CTRL_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ        20000000
`define TICK_MS       1
`define MS_CYCLES     (`CLK_HZ / 1000 * `TICK_MS)
`define PERIOD_UNIT_MS 20'd10
`define HOLD_UNIT_MS  7'd100
`define DISCARD_MS_X2 20'd25
`define PD_MAX        16'h68B0

// ----------------------------------------------------------------
// Command selectors
// ----------------------------------------------------------------
`define SEL_MD        4'h0
`define SEL_OP        4'h1
`define SEL_PD        4'h2
`define SEL_IW        4'h3
`define SEL_STATUS    4'h4
`define SEL_HOLD_BIT  3

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define OP_NO_POLL    0
`define OP_NO_SAMPLE  1
`define OP_MAX        8'h04
`define MD_RST        8'h00
`define OP_RST        8'h00
`define PD_RST        16'h0064
`define IW_RST        16'h1388
`define HOLD_RST      8'hFF

`endif

// >>> pkg/sleep_ctrl_pkg.sv
// Purpose: Types for the sleep controller.
// Assumes: Used with sleep_ctrl_defs.svh.
// Notes:   Mode codes are the selector values.
package sleep_ctrl_pkg;

    // Sleep selector decode
    typedef enum logic [2:0] {
        MODE_OFF      = 3'h0,
        MODE_PIN_HIB  = 3'h1,
        MODE_PIN_DOZE = 3'h2,
        MODE_RSVD     = 3'h3,
        MODE_CYC      = 3'h4,
        MODE_CYC_PIN  = 3'h5,
        MODE_COORD    = 3'h6
    } sleep_mode_t;

    // Power state, one-hot
    typedef enum logic [3:0] {
        S_AWAKE  = 4'b0001,
        S_ASLEEP = 4'b0010,
        S_POLL   = 4'b0100,
        S_PINSLP = 4'b1000
    } sleep_state_t;

endpackage : sleep_ctrl_pkg

// >>> rtl/line_hold_timer.sv
// Purpose: Output timeout for one passed I/O line.
// Assumes: tick_i is a one-cycle 100 ms pulse.
// Notes:   First tick phase is free, so expiry is up to one unit early.
`timescale 1ns/1ns
module line_hold_timer (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    // Timing and setting
    input  wire logic       tick_i,
    input  wire logic [7:0] limit_i,
    // Line passing
    input  wire logic       update_i,
    input  wire logic       level_i,
    input  wire logic       default_i,
    output logic            line_o
);
    logic       held_reg;
    logic       lvl_reg;
    logic [7:0] cnt_reg;

    // Load on each valid packet, count down, drop back when it runs out
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            held_reg <= 1'b0;
            lvl_reg  <= 1'b0;
            cnt_reg  <= 8'h00;
        end else if (update_i) begin
            lvl_reg  <= level_i;
            held_reg <= (level_i != default_i);
            cnt_reg  <= limit_i;
        end else if (tick_i && held_reg && cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h01) begin
                held_reg <= 1'b0;
            end
        end
    end

    assign line_o = held_reg ? lvl_reg : default_i;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    upd_level_a: assert property (update_i |=> line_o == $past(level_i))
        else $error("line not set by packet");
    no_limit_a: assert property (held_reg && cnt_reg == 8'h00 && !update_i |=> held_reg)
        else $error("untimed line dropped");
    expire_a: assert property (tick_i && held_reg && cnt_reg == 8'h01 && !update_i
                               |=> line_o == default_i)
        else $error("line not returned to default");
endmodule : line_hold_timer

// >>> rtl/sleep_ctrl.sv
// Purpose: Sleep mode control, cyclic sleep and idle timers, message
//          discard timer and eight output timeout timers.
// Assumes: Settings arrive as single-cycle configuration commands.
// Notes:   Times run from a shared 1 ms tick.
`timescale 1ns/1ns
`include "sleep_ctrl_defs.svh"

module sleep_ctrl
    import sleep_ctrl_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    // Configuration commands
    input  wire logic        cfg_valid_i,
    input  wire logic        cfg_write_i,
    input  wire logic [3:0]  cfg_sel_i,
    input  wire logic [15:0] cfg_wdata_i,
    output logic             cfg_ack_o,
    output logic             cfg_err_o,
    output logic [15:0]      cfg_rdata_o,
    // Sleep control
    input  wire logic        activity_i,
    input  wire logic        sleep_pin_i,
    input  wire logic        data_pending_i,
    input  wire logic        poll_done_i,
    input  wire logic        sampling_en_i,
    output logic             sleep_o,
    output logic             poll_req_o,
    output logic             sample_req_o,
    // Indirect messages
    input  wire logic        coord_en_i,
    input  wire logic        msg_held_i,
    input  wire logic        msg_delivered_i,
    output logic             msg_discard_o,
    // Passed I/O lines
    input  wire logic [7:0]  io_update_i,
    input  wire logic [7:0]  io_level_i,
    input  wire logic [7:0]  io_default_i,
    output logic [7:0]       io_line_o
);

    // ----------------------------------------------------------------
    // Settings
    // ----------------------------------------------------------------
    logic [7:0]   md_reg;
    logic [7:0]   op_reg;
    logic [15:0]  pd_reg;
    logic [15:0]  iw_reg;
    logic [7:0]   hold_lim_reg [8];
    sleep_state_t state_reg;
    sleep_state_t state_next;

    // Write decode and range checks; a bad value keeps the old one
    wire wr_cmd   = cfg_valid_i && cfg_write_i;
    wire sel_hold = cfg_sel_i[`SEL_HOLD_BIT];
    wire md_ok    = cfg_wdata_i <= 16'(MODE_COORD)
                    && cfg_wdata_i != 16'(MODE_RSVD);
    wire op_ok    = cfg_wdata_i <= {8'h00, `OP_MAX};
    wire pd_ok    = cfg_wdata_i <= `PD_MAX;
    wire iw_ok    = cfg_wdata_i != 16'h0000;
    wire hold_ok  = cfg_wdata_i[15:8] == 8'h00;

    wire wr_md    = wr_cmd && cfg_sel_i == `SEL_MD && md_ok;
    wire wr_op    = wr_cmd && cfg_sel_i == `SEL_OP && op_ok;
    wire wr_pd    = wr_cmd && cfg_sel_i == `SEL_PD && pd_ok;
    wire wr_iw    = wr_cmd && cfg_sel_i == `SEL_IW && iw_ok;
    wire wr_hold  = wr_cmd && sel_hold && hold_ok;

    wire sel_known = sel_hold || cfg_sel_i <= `SEL_STATUS;
    wire wr_good  = wr_md || wr_op || wr_pd || wr_iw || wr_hold;
    wire cmd_ok   = sel_known && (!cfg_write_i || wr_good);

    // Read mux; status shows the power state
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (sel_hold) begin
            rd_mux = {8'h00, hold_lim_reg[cfg_sel_i[2:0]]};
        end else begin
            case (cfg_sel_i)
                `SEL_MD:     rd_mux = {8'h00, md_reg};
                `SEL_OP:     rd_mux = {8'h00, op_reg};
                `SEL_PD:     rd_mux = pd_reg;
                `SEL_IW:     rd_mux = iw_reg;
                `SEL_STATUS: rd_mux = {12'h000, state_reg};
                default:     rd_mux = 16'h0000;
            endcase
        end
    end

    // Scalar settings; selector comes up as zero, never sleeping
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            md_reg <= `MD_RST;
            op_reg <= `OP_RST;
            pd_reg <= `PD_RST;
            iw_reg <= `IW_RST;
        end else begin
            if (wr_md) md_reg <= cfg_wdata_i[7:0];
            if (wr_op) op_reg <= cfg_wdata_i[7:0];
            if (wr_pd) pd_reg <= cfg_wdata_i;
            if (wr_iw) iw_reg <= cfg_wdata_i;
        end
    end

    // Command answer, one cycle after the request
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cfg_ack_o   <= 1'b0;
            cfg_err_o   <= 1'b0;
            cfg_rdata_o <= 16'h0000;
        end else begin
            cfg_ack_o   <= cfg_valid_i;
            cfg_err_o   <= cfg_valid_i && !cmd_ok;
            if (cfg_valid_i) cfg_rdata_o <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    logic [14:0] ms_cnt_reg;
    logic [6:0]  hund_cnt_reg;

    wire ms_tick   = ms_cnt_reg == 15'(MS_CYCLES - 1);
    wire hund_tick = ms_tick && hund_cnt_reg == `HOLD_UNIT_MS - 7'd1;

    // One prescaler feeds every timer, so units share a phase
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ms_cnt_reg   <= 15'h0000;
            hund_cnt_reg <= 7'h00;
        end else begin
            ms_cnt_reg <= ms_tick ? 15'h0000 : ms_cnt_reg + 15'h0001;
            if (hund_tick) hund_cnt_reg <= 7'h00;
            else if (ms_tick) hund_cnt_reg <= hund_cnt_reg + 7'h01;
        end
    end

    // ----------------------------------------------------------------
    // Sleep sequencing
    // ----------------------------------------------------------------
    sleep_mode_t mode;
    assign mode = sleep_mode_t'(md_reg[2:0]);
    wire pin_mode = mode == MODE_PIN_HIB || mode == MODE_PIN_DOZE;
    wire cyc45    = mode == MODE_CYC || mode == MODE_CYC_PIN;
    wire coord    = coord_en_i || mode == MODE_COORD;

    logic [16:0] idle_cnt_reg;
    logic [19:0] per_cnt_reg;

    // Idle load is one more than the setting so the wait is never short
    wire [16:0] idle_load = {1'b0, iw_reg} + 17'h00001;
    wire [19:0] per_load  = 20'(pd_reg) * `PERIOD_UNIT_MS;
    wire idle_exp = cyc45 && ms_tick && idle_cnt_reg == 17'h00001
                    && !activity_i;
    wire per_exp  = per_cnt_reg == 20'h00000;
    wire pin_wake = mode == MODE_CYC_PIN && !sleep_pin_i;

    // Next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_AWAKE: begin
                if (pin_mode && sleep_pin_i) state_next = S_PINSLP;
                else if (idle_exp) state_next = S_ASLEEP;
            end
            S_PINSLP: begin
                if (!pin_mode || !sleep_pin_i) state_next = S_AWAKE;
            end
            S_ASLEEP: begin
                if (!cyc45 || pin_wake) state_next = S_AWAKE;
                else if (per_exp) state_next = S_POLL;
            end
            S_POLL: begin
                if (!cyc45 || op_reg[`OP_NO_POLL]) state_next = S_AWAKE;
                else if (poll_done_i) begin
                    state_next = data_pending_i ? S_AWAKE : S_ASLEEP;
                end
            end
            default: state_next = S_AWAKE;
        endcase
    end

    wire enter_poll  = state_next == S_POLL && state_reg != S_POLL;
    wire enter_sleep = state_next == S_ASLEEP && state_reg != S_ASLEEP;
    wire wake_ev     = (state_reg == S_ASLEEP && state_next != S_ASLEEP)
                       || (state_reg == S_PINSLP && state_next != S_PINSLP);

    // State and wake pulses
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_reg    <= S_AWAKE;
            poll_req_o   <= 1'b0;
            sample_req_o <= 1'b0;
        end else begin
            state_reg    <= state_next;
            poll_req_o   <= enter_poll && !op_reg[`OP_NO_POLL];
            sample_req_o <= wake_ev && sampling_en_i
                            && !op_reg[`OP_NO_SAMPLE];
        end
    end

    assign sleep_o = state_reg == S_ASLEEP || state_reg == S_PINSLP;

    // Idle and sleep period counters; traffic reloads the idle wait
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            idle_cnt_reg <= {1'b0, `IW_RST} + 17'h00001;
            per_cnt_reg  <= 20'h00000;
        end else begin
            if (activity_i || state_reg != S_AWAKE) idle_cnt_reg <= idle_load;
            else if (ms_tick && idle_cnt_reg > 17'h00001)
                idle_cnt_reg <= idle_cnt_reg - 17'h00001;
            if (enter_sleep) per_cnt_reg <= per_load;
            else if (ms_tick && !per_exp) per_cnt_reg <= per_cnt_reg - 20'h00001;
        end
    end

    // ----------------------------------------------------------------
    // Indirect message discard
    // ----------------------------------------------------------------
    // One message is timed at a time; a new one restarts the wait
    logic [19:0] disc_cnt_reg;

    wire        disc_on   = coord && pd_reg != 16'h0000;
    wire [19:0] disc_load = 20'(pd_reg) * `DISCARD_MS_X2;
    wire        disc_exp  = disc_on && ms_tick && disc_cnt_reg == 20'h00001;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            disc_cnt_reg  <= 20'h00000;
            msg_discard_o <= 1'b0;
        end else begin
            msg_discard_o <= disc_exp;
            if (!disc_on) disc_cnt_reg <= 20'h00000;
            else if (msg_held_i) disc_cnt_reg <= disc_load;
            else if (msg_delivered_i) disc_cnt_reg <= 20'h00000;
            else if (ms_tick && disc_cnt_reg != 20'h00000)
                disc_cnt_reg <= disc_cnt_reg - 20'h00001;
        end
    end

    // ----------------------------------------------------------------
    // Output timeout per passed line
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_line
        always_ff @(posedge clk_sys_i) begin
            if (reset_i) hold_lim_reg[i] <= `HOLD_RST;
            else if (wr_hold && cfg_sel_i[2:0] == 3'(i))
                hold_lim_reg[i] <= cfg_wdata_i[7:0];
        end

        line_hold_timer u_hold (
            .clk_sys_i (clk_sys_i),
            .reset_i   (reset_i),
            .tick_i    (hund_tick),
            .limit_i   (hold_lim_reg[i]),
            .update_i  (io_update_i[i]),
            .level_i   (io_level_i[i]),
            .default_i (io_default_i[i]),
            .line_o    (io_line_o[i])
        );
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    off_no_sleep_a: assert property (mode == MODE_OFF |=> !sleep_o)
        else $error("slept while sleep disabled");

    rsvd_refused_a: assert property (wr_cmd && cfg_sel_i == `SEL_MD
        && cfg_wdata_i == 16'h0003 |=> cfg_err_o && $stable(md_reg))
        else $error("reserved selector accepted");

    poll_skip_a: assert property (state_reg == S_POLL && op_reg[`OP_NO_POLL]
        |-> !poll_req_o ##1 state_reg == S_AWAKE)
        else $error("poll not skipped");

    sample_gate_a: assert property (sample_req_o
        |-> $past(sampling_en_i) && !$past(op_reg[`OP_NO_SAMPLE]))
        else $error("sample without cause");

    period_load_a: assert property (state_reg == S_ASLEEP
        && $past(state_reg) != S_ASLEEP |-> per_cnt_reg == $past(per_load))
        else $error("sleep period not loaded");

    back_asleep_a: assert property (state_reg == S_POLL && cyc45
        && !op_reg[`OP_NO_POLL] && poll_done_i && !data_pending_i
        |=> state_reg == S_ASLEEP)
        else $error("no return to sleep");

    cyc_only_a: assert property (state_reg == S_ASLEEP && !cyc45
        |=> state_reg == S_AWAKE)
        else $error("cyclic sleep outside cyclic modes");

    idle_gate_a: assert property (state_reg == S_AWAKE && !cyc45 && !pin_mode
        |=> state_reg == S_AWAKE)
        else $error("idle sleep outside cyclic modes");

    idle_reload_a: assert property (activity_i
        |=> idle_cnt_reg == $past(idle_load))
        else $error("traffic did not restart idle");

    discard_a: assert property (msg_discard_o
        |-> $past(disc_cnt_reg) == 20'h00001 && $past(disc_on))
        else $error("discard without timeout");

    cover property (state_reg == S_POLL ##1 state_reg == S_ASLEEP);

    cover property (msg_discard_o);

    cover property (state_reg == S_PINSLP ##1 state_reg == S_AWAKE);

    cover property (sample_req_o && poll_req_o);
endmodule : sleep_ctrl

// >>> tb/host_cfg_model.sv
// Purpose: Host side of the configuration port, one command at a time.
// Assumes: Commands launched on the falling edge, one-cycle strobe, answer a cycle later.
// Notes:   Write data is inverted once the strobe drops, so a late sample shows up.
`timescale 1ns/1ns
module host_cfg_model (
    // Clock
    input  wire logic        clk_sys_i,
    // Command side
    output logic             cfg_valid_o,
    output logic             cfg_write_o,
    output logic [3:0]       cfg_sel_o,
    output logic [15:0]      cfg_wdata_o,
    // Answer side
    input  wire logic        cfg_ack_i,
    input  wire logic        cfg_err_i,
    input  wire logic [15:0] cfg_rdata_i
);
    // Idle port at time zero
    initial begin
        cfg_valid_o = 1'b0;
        cfg_write_o = 1'b0;
        cfg_sel_o   = 4'h0;
        cfg_wdata_o = 16'h0000;
    end

    // One strobe per command; answer waited for under a bound of three cycles
    task automatic cmd(input logic wr, input logic [3:0] sel, input logic [15:0] wd,
                       output logic err, output logic [15:0] rd, output logic got);
        got = 1'b0;
        err = 1'b0;
        rd  = 16'h0000;
        @(negedge clk_sys_i);
        cfg_valid_o <= 1'b1;
        cfg_write_o <= wr;
        cfg_sel_o   <= sel;
        cfg_wdata_o <= wd;
        @(negedge clk_sys_i);
        cfg_valid_o <= 1'b0;
        cfg_wdata_o <= ~wd;
        for (int n = 0; n < 3 && !got; n++) begin
            if (cfg_ack_i === 1'b1) begin
                got = 1'b1;
                err = cfg_err_i;
                rd  = cfg_rdata_i;
            end else begin
                @(negedge clk_sys_i);
            end
        end
    endtask : cmd
endmodule : host_cfg_model

// >>> tb/tb_sleep_ctrl.sv
// Purpose: Self-checking bench for the sleep controller and line timers.
// Assumes: Millisecond tick shortened to 20 cycles; inputs move on the falling edge.
// Notes:   Pulse outputs are counted at the falling edge, where they have settled.
`timescale 1ns/1ns
module tb_sleep_ctrl
    import sleep_ctrl_pkg::*;
;
    localparam int MS = 20;
    localparam logic [3:0]  BAD_SEL [8] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8};
    localparam logic [15:0] BAD_VAL [8] = '{16'h0003, 16'h0007, 16'h0005, 16'h68B1,
                                            16'h0000, 16'h0001, 16'h0000, 16'h0100};
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        clk = 1'b0, rst = 1'b1, activity = 1'b0, sleep_pin = 1'b0;
    logic        data_pending = 1'b0, poll_done = 1'b0, sampling = 1'b0, coord = 1'b0;
    logic        msg_held = 1'b0, msg_delivered = 1'b0;
    logic [7:0]  io_update = 8'h00, io_level = 8'h00, io_default = 8'hF0;
    logic        cfg_valid, cfg_write, cfg_ack, cfg_err, asleep, poll_req, sample_req, discard;
    logic [3:0]  cfg_sel;
    logic [15:0] cfg_wdata, cfg_rdata, rd;
    logic [7:0]  io_line;
    int          failures = 0, num_checks = 0, n_poll = 0, n_samp = 0, n_disc = 0, w;

    sleep_ctrl #(.MS_CYCLES(MS)) sleep_ctrl_inst (
        .clk_sys_i(clk), .reset_i(rst), .cfg_valid_i(cfg_valid), .cfg_write_i(cfg_write),
        .cfg_sel_i(cfg_sel), .cfg_wdata_i(cfg_wdata), .cfg_ack_o(cfg_ack),
        .cfg_err_o(cfg_err), .cfg_rdata_o(cfg_rdata), .activity_i(activity),
        .sleep_pin_i(sleep_pin), .data_pending_i(data_pending), .poll_done_i(poll_done),
        .sampling_en_i(sampling), .sleep_o(asleep), .poll_req_o(poll_req),
        .sample_req_o(sample_req), .coord_en_i(coord), .msg_held_i(msg_held),
        .msg_delivered_i(msg_delivered), .msg_discard_o(discard), .io_update_i(io_update),
        .io_level_i(io_level), .io_default_i(io_default), .io_line_o(io_line));

    host_cfg_model host_cfg_model_inst (
        .clk_sys_i(clk), .cfg_valid_o(cfg_valid), .cfg_write_o(cfg_write),
        .cfg_sel_o(cfg_sel), .cfg_wdata_o(cfg_wdata), .cfg_ack_i(cfg_ack),
        .cfg_err_i(cfg_err), .cfg_rdata_i(cfg_rdata));

    // Clock and pulse counters; counting avoids racing one-cycle pulses
    always #25 clk = ~clk;
    always @(negedge clk) begin
        if (poll_req === 1'b1) n_poll++;
        if (sample_req === 1'b1) n_samp++;
        if (discard === 1'b1) n_disc++;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check1(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : check1
    task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check16
    task automatic checkn(input int got, input int exp, input string what);
        num_checks++;
        if (got != exp) begin
            failures++;
            $display("Error at %0t ns: %s count %0d expected %0d", $time, what, got, exp);
        end
    endtask : checkn
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_cyc
    task automatic wait_sleep(input logic exp, input int max);
        for (w = 0; w < max && asleep !== exp; w++) @(negedge clk);
        check1(asleep, exp, "sleep level");
    endtask : wait_sleep
    task automatic access(input logic wr, input logic [3:0] sel, input logic [15:0] wd,
                          input logic exp_err);
        logic err;
        logic got;
        host_cfg_model_inst.cmd(wr, sel, wd, err, rd, got);
        check1(got, 1'b1, "command answered");
        check1(err, exp_err, "command refusal");
    endtask : access
    task automatic set_reg(input logic [3:0] sel, input logic [15:0] val);
        access(1'b1, sel, val, 1'b0);
    endtask : set_reg
    task automatic get_reg(input logic [3:0] sel, input logic [15:0] exp);
        access(1'b0, sel, 16'h0000, 1'b0);
        check16(rd, exp, "readback");
    endtask : get_reg
    // Single-cycle pulse on one of the event inputs
    task automatic pulse_in(input int which);
        case (which)
            0: activity <= 1'b1;
            1: poll_done <= 1'b1;
            2: msg_held <= 1'b1;
            default: msg_delivered <= 1'b1;
        endcase
        @(negedge clk);
        {activity, poll_done, msg_held, msg_delivered} <= 4'h0;
    endtask : pulse_in
    task automatic do_reset();
        rst <= 1'b1;
        {sleep_pin, data_pending, sampling, coord} <= 4'h0;
        wait_cyc(3);
        rst <= 1'b0;
        {n_poll, n_samp, n_disc} = '0;
    endtask : do_reset

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset_values();
        do_reset();
        get_reg(4'h0, 16'h0000);
        get_reg(4'h1, 16'h0000);
        get_reg(4'h2, 16'h0064);
        get_reg(4'h3, 16'h1388);
        get_reg(4'h4, {12'h000, S_AWAKE});
        for (int i = 8; i < 16; i++) get_reg(4'(i), 16'h00FF);
        wait_cyc(300);
        check1(asleep, 1'b0, "disabled mode stays awake");
    endtask : test_reset_values

    // Out-of-range writes must leave mode, period, idle and the first line limit untouched; the period and idle edges are accepted
    task automatic test_refusals();
        do_reset();
        for (int i = 0; i < 8; i++) access(1'b1, BAD_SEL[i], BAD_VAL[i], 1'b1);
        get_reg(4'h0, 16'h0000);
        get_reg(4'h2, 16'h0064);
        get_reg(4'h3, 16'h1388);
        get_reg(4'h8, 16'h00FF);
        set_reg(4'h2, 16'h68B0);
        get_reg(4'h2, 16'h68B0);
        set_reg(4'h3, 16'hFFFF);
        get_reg(4'h3, 16'hFFFF);
    endtask : test_refusals

    // Only the cyclic remote modes sleep on idle; pin modes follow the pin
    task automatic test_modes();
        for (int m = 0; m < 7; m++) begin
            do_reset();
            sleep_pin <= (m == 5);
            set_reg(4'h3, 16'h0002);
            access(1'b1, 4'h0, 16'(m), m == 3);
            pulse_in(0);
            wait_cyc(5 * MS);
            check1(asleep, m == 4 || m == 5, "idle sleep by mode");
            sleep_pin <= 1'b0;
            wait_cyc(2);
            check1(asleep, m == 4, "pin wake");
        end
        for (int m = 1; m < 3; m++) begin
            do_reset();
            set_reg(4'h0, 16'(m));
            wait_cyc(5 * MS);
            check1(asleep, 1'b0, "pin mode ignores idle");
            sleep_pin <= 1'b1;
            wait_cyc(4);
            check1(asleep, 1'b1, "pin mode sleeps on pin");
        end
    endtask : test_modes

    // Activity keeps restarting the idle count
    task automatic test_activity();
        do_reset();
        set_reg(4'h3, 16'h0003);
        set_reg(4'h0, 16'h0004);
        for (int i = 0; i < 6; i++) begin
            pulse_in(0);
            wait_cyc(2 * MS);
            check1(asleep, 1'b0, "awake while active");
        end
        wait_sleep(1'b1, 6 * MS);
    endtask : test_activity

    task automatic test_cyclic(input logic [15:0] opt);
        do_reset();
        sampling <= 1'b1;
        set_reg(4'h1, opt);
        set_reg(4'h3, 16'h0002);
        set_reg(4'h2, 16'h0001);
        set_reg(4'h0, 16'h0004);
        pulse_in(0);
        wait_sleep(1'b1, 6 * MS);
        {n_poll, n_samp} = '0;
        wait_sleep(1'b0, 12 * MS);
        check1(w > 8 * MS, 1'b1, "period length");
        wait_cyc(3);
        checkn(n_poll, opt[0] ? 0 : 1, "wake polls");
        checkn(n_samp, opt[1] ? 0 : 1, "wake samples");
        if (!opt[0]) begin
            pulse_in(1);
            check1(asleep, 1'b1, "empty poll sleeps again");
            wait_sleep(1'b0, 12 * MS);
            data_pending <= 1'b1;
            pulse_in(1);
            wait_cyc(5);
            check1(asleep, 1'b0, "pending data keeps awake");
        end
    endtask : test_cyclic

    task automatic test_discard();
        do_reset();
        coord <= 1'b1;
        set_reg(4'h2, 16'h0001);
        pulse_in(2);
        wait_cyc(23 * MS);
        checkn(n_disc, 0, "held message kept");
        wait_cyc(4 * MS);
        checkn(n_disc, 1, "held message dropped");
        pulse_in(2);
        wait_cyc(5 * MS);
        pulse_in(3);
        wait_cyc(30 * MS);
        checkn(n_disc, 1, "delivered message not dropped");
        set_reg(4'h2, 16'h0000);
        pulse_in(2);
        wait_cyc(30 * MS);
        checkn(n_disc, 1, "zero period holds no timer");
    endtask : test_discard

    task automatic test_lines();
        do_reset();
        set_reg(4'h8, 16'h0003);
        set_reg(4'h9, 16'h0000);
        io_level  <= 8'h03;
        io_update <= 8'h03;
        @(negedge clk);
        io_update <= 8'h00;
        wait_cyc(1);
        check16({8'h00, io_line}, 16'h00F3, "lines driven");
        wait_cyc(3900);
        check1(io_line[0], 1'b1, "held before limit");
        io_update <= 8'h01;
        @(negedge clk);
        io_update <= 8'h00;
        wait_cyc(3900);
        check1(io_line[0], 1'b1, "restarted hold");
        wait_cyc(4200);
        check16({8'h00, io_line}, 16'h00F2, "back to default, zero limit held");
    endtask : test_lines

    task automatic complete_run();
        $display("Checks: %0d, failures: %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // Main sequence and watchdog (about 2.4 times the expected run)
    // ----------------------------------------------------------------
    initial begin
        test_reset_values();
        test_refusals();
        test_modes();
        test_activity();
        test_cyclic(16'h0000);
        test_cyclic(16'h0001);
        test_cyclic(16'h0002);
        test_discard();
        test_lines();
        complete_run();
    end
    initial begin
        #(40000 * 50);
        failures++;
        complete_run();
    end
endmodule : tb_sleep_ctrl
